// ### common/guard_if.sv
// Interface between the guard top and its oscillator-tick counter.
// Assumes one clock domain, clk_in.
`timescale 1ns/1ps
interface guard_if;
	logic tick;
	logic start;
	logic clear;
	logic [15:0] count;
	modport ctl (output start, output clear, output tick, input count);
	modport cnt (input start, input clear, input tick, output count);
endinterface

// ### common/guard_pkg.sv
// Package with the timing constants and state types of the bus guard.
// Assumes a 50 MHz system clock and a 32.768 kHz oscillator tick sampled as a pin.
package guard_pkg;
	// ---------------------------------------------------------------
	// Clock and oscillator
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 50000000;
	localparam int OSC_HZ = 32768;
	// ---------------------------------------------------------------
	// Times, as printed, in milliseconds
	// ---------------------------------------------------------------
	localparam int TIMEOUT_MS = 950;
	localparam int RESET_DELAY_MS = 60;
	localparam int INITIAL_RESET_DELAY_MS = 250;
	localparam int BACKUP_SAMPLE_MAX_MS = 35;
	// ---------------------------------------------------------------
	// Counts in oscillator ticks (least times round up)
	// ---------------------------------------------------------------
	localparam int TIMEOUT_TICKS = (TIMEOUT_MS * OSC_HZ + 999) / 1000;
	localparam int RESET_DELAY_TICKS = (RESET_DELAY_MS * OSC_HZ + 999) / 1000;
	localparam int INITIAL_RESET_DELAY_TICKS = (INITIAL_RESET_DELAY_MS * OSC_HZ + 999) / 1000;
	localparam int BACKUP_SAMPLE_TICKS = (BACKUP_SAMPLE_MAX_MS * OSC_HZ) / 1000;
	localparam int TICK_W = 16;
	// ---------------------------------------------------------------
	// States
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {BUS_IDLE, BUS_ACTIVE} bus_state_t;
	typedef enum logic [2:0] {PWR_OFF, PWR_INITIAL, PWR_BACKUP_WAIT, PWR_RECOVER, PWR_RUN} pwr_state_t;
endpackage

// ### hw/rtc_bus_timeout_access_guard.sv
// Bus timeout, timekeeping hold and supply reset windows of a real-time clock.
// Assumes scl, sda, the oscillator and the supply detectors arrive as pins.
//
// How it works
// - Reset bus interface after 0.95 s transaction
// - Timeout releases data line to input
// - Timekeeping held while time registers accessed
// - Reset output held for 60 ms
// - Initial power-on releases reset after 250 ms
// - Backup recovery releases reset within 60-95 ms
// - Supply-loss flag set on possible corruption
// - Time counting stops during serial transaction
`timescale 1ns/1ps
module rtc_bus_timeout_access_guard
	import guard_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Pins from outside
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic osc_in,
	input wire logic supply_ok_in,
	input wire logic backup_switch_detector_in,
	// Serial engine side
	input wire logic engine_sda_drive_in,
	input wire logic supply_loss_clear_in,
	// Outputs
	output logic sda_out,
	output logic sda_oe_out,
	output logic bus_reset_out,
	output logic bus_active_out,
	output logic time_hold_out,
	output logic rst_n_out,
	output logic supply_loss_flag_out
);
	import guard_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Two flops each; the second stage and a third, prev_reg, kept for edges are looked at
	logic [4:0] sync1_reg, sync2_reg, prev_reg;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			sync1_reg <= 5'h03;
			sync2_reg <= 5'h03;
			prev_reg <= 5'h03;
		end else begin
			sync1_reg <= {backup_switch_detector_in, supply_ok_in, osc_in, sda_in, scl_in};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end
	logic scl_s, sda_s, osc_s, sup_s, bk_s;
	assign {bk_s, sup_s, osc_s, sda_s, scl_s} = sync2_reg;
	logic osc_tick, start_cond, stop_cond;
	assign osc_tick = osc_s && !prev_reg[2];
	// Start and stop are data edges while clock high
	assign start_cond = scl_s && prev_reg[0] && !sda_s && prev_reg[1];
	assign stop_cond = scl_s && prev_reg[0] && sda_s && !prev_reg[1];

	// ---------------------------------------------------------------
	// Transaction timeout
	// ---------------------------------------------------------------
	guard_if gi();
	tick_counter u_cnt (.clk_in(clk_in), .rstn_in(rstn_in), .c(gi.cnt));
	bus_state_t bus_reg, bus_next;
	logic timeout, bus_reset_reg, bus_reset_next;
	assign timeout = (bus_reg == BUS_ACTIVE) && (gi.count >= TICK_W'(TIMEOUT_TICKS));
	assign gi.tick = osc_tick;
	assign gi.start = start_cond && rst_n_out;
	assign gi.clear = stop_cond || timeout || !rst_n_out;
	always_comb begin
		bus_next = bus_reg;
		bus_reset_next = 1'b0;
		case (bus_reg)
			BUS_IDLE: begin
				// Without a start nothing is decoded, so an address never shifts
				if (start_cond && rst_n_out) begin
					bus_next = BUS_ACTIVE;
				end
			end
			BUS_ACTIVE: begin
				if (timeout || !rst_n_out) begin
					bus_next = BUS_IDLE;
					bus_reset_next = 1'b1;
				end else if (stop_cond) begin
					bus_next = BUS_IDLE;
				end
			end
			default: bus_next = BUS_IDLE;
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			bus_reg <= BUS_IDLE;
			bus_reset_reg <= 1'b0;
		end else begin
			bus_reg <= bus_next;
			bus_reset_reg <= bus_reset_next;
		end
	end
	assign bus_active_out = (bus_reg == BUS_ACTIVE);
	assign bus_reset_out = bus_reset_reg;
	// Engine may only pull low while a transaction stands
	assign sda_oe_out = engine_sda_drive_in && (bus_reg == BUS_ACTIVE) && !timeout;
	assign sda_out = 1'b0;
	// Lost up to a second if the host stalls: the hold only ends at stop, timeout or reset output low
	assign time_hold_out = (bus_reg == BUS_ACTIVE);

	// ---------------------------------------------------------------
	// Supply reset windows
	// ---------------------------------------------------------------
	pwr_state_t pwr_reg, pwr_next;
	logic [TICK_W-1:0] dly_reg, dly_next;
	logic flag_reg, flag_next, rst_n_reg, rst_n_next;
	always_comb begin
		pwr_next = pwr_reg;
		dly_next = dly_reg;
		flag_next = flag_reg;
		rst_n_next = 1'b0;
		if (osc_tick && dly_reg != '0) begin
			dly_next = dly_reg - 16'h0001;
		end
		case (pwr_reg)
			PWR_OFF: begin
				if (sup_s) begin
					pwr_next = PWR_INITIAL;
					dly_next = TICK_W'(INITIAL_RESET_DELAY_TICKS);
				end
			end
			PWR_INITIAL, PWR_RECOVER: begin
				if (!sup_s) begin
					pwr_next = PWR_BACKUP_WAIT;
				end else if (dly_reg == '0) begin
					pwr_next = PWR_RUN;
				end
			end
			PWR_BACKUP_WAIT: begin
				if (sup_s && bk_s) begin
					// Detector samples intermittently, so the window is 60 ms plus its lag
					pwr_next = PWR_RECOVER;
					dly_next = TICK_W'(RESET_DELAY_TICKS);
				end
			end
			PWR_RUN: begin
				rst_n_next = sup_s;
				if (!sup_s) begin
					pwr_next = PWR_BACKUP_WAIT;
				end
			end
			default: pwr_next = PWR_OFF;
		endcase
		// Set beats clear: a supply drop with the backup detector low always leaves the flag up
		if (supply_loss_clear_in) begin
			flag_next = 1'b0;
		end
		if (!sup_s && !bk_s) begin
			flag_next = 1'b1;
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			pwr_reg <= PWR_OFF;
			dly_reg <= '0;
			flag_reg <= 1'b1;
			rst_n_reg <= 1'b0;
		end else begin
			pwr_reg <= pwr_next;
			dly_reg <= dly_next;
			flag_reg <= flag_next;
			rst_n_reg <= rst_n_next;
		end
	end
	assign rst_n_out = rst_n_reg;
	assign supply_loss_flag_out = flag_reg;
endmodule // rtc_bus_timeout_access_guard

// ### hw/tick_counter.sv
// Counts oscillator ticks between a start and a clear.
// Assumes tick is a one-cycle pulse already in the clk_in domain.
`timescale 1ns/1ps
module tick_counter
	import guard_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Control
	guard_if.cnt c
);
	logic [TICK_W-1:0] count_reg, count_next;
	logic run_reg, run_next;
	always_comb begin
		count_next = count_reg;
		run_next = run_reg;
		if (c.clear) begin
			count_next = '0;
			run_next = 1'b0;
		end else if (c.start) begin
			count_next = '0;
			run_next = 1'b1;
		end else if (run_reg && c.tick && count_reg != '1) begin
			count_next = count_reg + 16'h0001;
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			count_reg <= '0;
			run_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			run_reg <= run_next;
		end
	end
	assign c.count = count_reg;
endmodule // tick_counter

// ### sim/guard_sva.sv
// Checker on the top ports of the bus guard.
// Assumes one clk_in domain with a sync active-low reset.
`timescale 1ns/1ps
module guard_sva (
	input wire logic clk_in, rstn_in, scl_in, sda_in, supply_ok_in, backup_switch_detector_in,
	input wire logic engine_sda_drive_in, sda_out, sda_oe_out, bus_reset_out, bus_active_out,
	input wire logic time_hold_out, rst_n_out, supply_loss_flag_out
);
	// ----
	// Properties
	// ----
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Cycles spent in one transaction; a counter, as a repetition would be far too long
	int run_reg = 0;
	always_ff @(posedge clk_in) run_reg <= bus_active_out ? run_reg + 1 : 0;
	oe_gate_a: assert property (sda_oe_out |-> bus_active_out && engine_sda_drive_in) else $error("drive idle");
	open_drain_a: assert property (sda_out == 1'b0) else $error("data value high");
	reset_pulse_a: assert property (bus_reset_out |-> !bus_active_out ##1 !bus_reset_out) else $error("pulse");
	timeout_cap_a: assert property (run_reg < 62300) else $error("no timeout");
	hold_track_a: assert property (time_hold_out == bus_active_out) else $error("hold differs");
	start_seen_a: assert property ($fell(sda_in) && scl_in && rst_n_out |-> ##[1:6] bus_active_out) else $error("start");
	reset_drop_a: assert property ($fell(supply_ok_in) |-> ##[1:6] !rst_n_out) else $error("reset out");
	flag_set_a: assert property ((!supply_ok_in && !backup_switch_detector_in) [*4] |-> supply_loss_flag_out)
		else $error("flag");
	cover property (bus_reset_out);
	cover property ($rose(rst_n_out));
	cover property (sda_oe_out);
endmodule // guard_sva

// ### sim/host_model.sv
// Bus host model that drives clock and data pins.
// Assumes the bench wires data open drain with a pull-up.
`timescale 1ns/1ps
module host_model (
	output logic scl_out,
	output logic sda_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// Start always goes out before any address bit
	task automatic start();
		sda_out = 1'b0;
		#1000 scl_out = 1'b0;
		#1000;
	endtask
	// Normal stop comes well inside the timeout and before backup
	task automatic stop();
		sda_out = 1'b0;
		#1000 scl_out = 1'b1;
		#1000 sda_out = 1'b1;
		#1000;
	endtask
endmodule // host_model

// ### sim/testbench.sv
// Self-checking bench of the bus guard.
// Assumes a free-running oscillator pin with a 40 ns period, so the long windows fit a short run.
`timescale 1ns/1ps
module testbench;
	import guard_pkg::*;
	logic clk_in = 1'b0, rstn_in = 1'b0, osc_in = 1'b0, sup = 1'b1, det = 1'b1, eng = 1'b0, clr = 1'b0;
	logic scl, hsda, sda_out, sda_oe_out, bus_reset_out, bus_active_out, time_hold_out, rst_n_out, flag;
	wire sda_line = hsda & ~sda_oe_out;
	int n_fail = 0, checks_done = 0, n;
	logic [2:0] rows [3] = '{3'b000, 3'b100, 3'b111};
	always #10 clk_in = ~clk_in;
	always #20 osc_in = ~osc_in;
	host_model i_host_model (.scl_out(scl), .sda_out(hsda));
	rtc_bus_timeout_access_guard i_rtc_bus_timeout_access_guard (.clk_in(clk_in), .rstn_in(rstn_in),
		.scl_in(scl), .sda_in(sda_line), .osc_in(osc_in), .supply_ok_in(sup), .backup_switch_detector_in(det),
		.engine_sda_drive_in(eng), .supply_loss_clear_in(clr), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
		.bus_reset_out(bus_reset_out), .bus_active_out(bus_active_out), .time_hold_out(time_hold_out),
		.rst_n_out(rst_n_out), .supply_loss_flag_out(flag));
	// ----
	// Tasks
	// ----
	task automatic check(string what, logic exp, logic got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic cyc(int k);
		repeat (k) @(negedge clk_in);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		cyc(10);
		rstn_in = 1'b1;
		check("flag_reset", 1'b1, flag);
		n = 0;
		// No access until the reset output lets go
		while (rst_n_out !== 1'b1 && n < 18000) begin cyc(1); n++; end
		check("power_on_delay", 1'b1, n > 16350 && n < 16450);
		$display("test power_on done");
		foreach (rows[i]) begin
			if (rows[i][2]) i_host_model.start();
			eng = rows[i][1];
			cyc(1);
			check("sda_drive", rows[i][0], sda_oe_out);
			check("time_hold", rows[i][2], time_hold_out);
			eng = 1'b0;
			if (rows[i][2]) i_host_model.stop();
			cyc(4);
			check("stop_idle", 1'b0, bus_active_out);
		end
		$display("test rows done");
		// Initialisation after power-on clears the flag
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		cyc(2);
		check("flag_clear", 1'b0, flag);
		// Host stalls with the engine still driving; only the timeout can end it
		i_host_model.start();
		eng = 1'b1;
		n = 0;
		while (bus_reset_out !== 1'b1 && n < 64000) begin cyc(1); n++; end
		check("timeout_span", 1'b1, n > 62120 && n < 62200);
		check("timeout_idle", 1'b0, bus_active_out);
		check("timeout_release", 1'b0, sda_oe_out);
		eng = 1'b0;
		i_host_model.stop();
		$display("test timeout done");
		sup = 1'b0;
		det = 1'b0;
		cyc(8);
		check("reset_out_low", 1'b0, rst_n_out);
		check("flag_loss", 1'b1, flag);
		i_host_model.start();
		check("start_refused", 1'b0, bus_active_out);
		i_host_model.stop();
		sup = 1'b1;
		det = 1'b1;
		n = 0;
		// No access until the reset output lets go
		while (rst_n_out !== 1'b1 && n < 5000) begin cyc(1); n++; end
		check("backup_delay", 1'b1, n > 3900 && n < 3970);
		// Flag seen high, so initialise as at power-on
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		cyc(2);
		check("flag_reinit", 1'b0, flag);
		$display("test backup done");
		summarize();
	end
	initial begin
		#2000000;
		n_fail++;
		summarize();
	end
endmodule // testbench
bind rtc_bus_timeout_access_guard guard_sva i_guard_sva (.*);
